// ### hw/dis_decoder_interrupt_status.sv
// Summary of operation
// - Header byte after sync in monitor/write/realtime modes sets decoder flag
// - With sync window open, sync spacing under 2352 bytes suppresses it
// - Each repeat-correction pass completion sets decoder flag
// - Audio mode sets decoder flag every 2352 bytes written to buffer
// - Subcode buffering sets decoder flag after one sector of subcode
// - No sync within 40.6 ms after entering search mode sets timeout flag
// - Buffering reaching buffer limit address in write/realtime/audio sets overrun
// - Completion of data-sector correction sets correction-done flag
// - Recordable-disc condition drives group 0 bit 3 high
// - Short sync flagged only in monitor, write, realtime, async correction modes
// - Timer flag set when programmed high/low interval runs out
// - Subcode sync while fetching enabled sets subcode-sync flag
// - Flag uncleared 95 word clocks blocks next set and subcode-Q update
// - Group 1 flags set and held regardless of enable bits
// - Writing one to group 0 clear bit clears its flag, self-clearing
// - Writing one to group 1 clear bit 1 or 0 clears its flag
// - Interrupt output active when any enabled flag is set
module dis_decoder_interrupt_status #(
    parameter int TIMEOUT_CYC = dis_pkg::DEC_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Decoder side
    input wire dis_pkg::dis_mode_t dec_mode,
    input wire dis_pkg::dis_evt_t evt,
    input wire logic sync_window_open,
    input wire logic subc_fetch_en,
    input wire logic [19:0] buf_wr_addr,
    // Results
    output logic subcode_q_update,
    output logic irq
);

    // ------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------
    logic wr_acc;
    logic [7:0] idx;
    logic idx_ok;
    logic [7:0] wbyte;

    assign wr_acc = psel & penable & pwrite;
    assign idx = paddr[9:2];
    assign wbyte = pwdata[7:0];
    assign pready = 1'b1;
    always_comb begin
        unique case (idx)
            dis_pkg::IDX_EVT_STATUS, dis_pkg::IDX_TS_STATUS,
            dis_pkg::IDX_EVT_ENABLE, dis_pkg::IDX_TS_ENABLE,
            dis_pkg::IDX_TIMER_HIGH, dis_pkg::IDX_TIMER_LOW,
            dis_pkg::IDX_TIMER_CTRL, dis_pkg::IDX_BUF_LIMIT: idx_ok = 1'b1;
            default: idx_ok = 1'b0;
        endcase
        if (paddr[11:10] != 2'b00 || paddr[1:0] != 2'b00) begin
            idx_ok = 1'b0;
        end
    end

    logic wr_evt_clr;
    logic wr_ts_clr;
    assign wr_evt_clr = wr_acc && idx_ok && idx == dis_pkg::IDX_EVT_STATUS;
    assign wr_ts_clr = wr_acc && idx_ok && idx == dis_pkg::IDX_TS_STATUS;

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    logic [7:0] evt_en_ff;
    logic [7:0] ts_en_ff;
    logic [7:0] timer_hi_ff;
    logic [7:0] timer_lo_ff;
    logic [19:0] buf_limit_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_en_ff <= dis_pkg::RST_BYTE;
            ts_en_ff <= dis_pkg::RST_BYTE;
            timer_hi_ff <= dis_pkg::RST_BYTE;
            timer_lo_ff <= dis_pkg::RST_BYTE;
            buf_limit_ff <= dis_pkg::RST_BUF_LIMIT;
        end else if (wr_acc && idx_ok) begin
            unique case (idx)
                dis_pkg::IDX_EVT_ENABLE: evt_en_ff <= wbyte & dis_pkg::EVT_MASK;
                dis_pkg::IDX_TS_ENABLE: ts_en_ff <= wbyte & dis_pkg::TS_MASK;
                dis_pkg::IDX_TIMER_HIGH: timer_hi_ff <= wbyte;
                dis_pkg::IDX_TIMER_LOW: timer_lo_ff <= wbyte;
                dis_pkg::IDX_BUF_LIMIT: buf_limit_ff <= pwdata[19:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Mode classes
    // ------------------------------------------------------------
    logic search_mode;
    logic overrun_mode;
    logic short_mode;
    dis_pkg::dis_mode_t mode_ff;

    assign search_mode = dec_mode == dis_pkg::DIS_MODE_MONITOR_ONLY ||
                         dec_mode == dis_pkg::DIS_MODE_WRITE_ONLY ||
                         dec_mode == dis_pkg::DIS_MODE_REALTIME_CORR;
    assign overrun_mode = dec_mode == dis_pkg::DIS_MODE_WRITE_ONLY ||
                          dec_mode == dis_pkg::DIS_MODE_REALTIME_CORR ||
                          dec_mode == dis_pkg::DIS_MODE_CDDA;
    assign short_mode = search_mode ||
                        dec_mode == dis_pkg::DIS_MODE_ASYNC_CORR;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ff <= dis_pkg::DIS_MODE_IDLE;
        end else begin
            mode_ff <= dec_mode;
        end
    end

    // ------------------------------------------------------------
    // Sync spacing
    // ------------------------------------------------------------
    logic [11:0] sync_gap_ff;
    logic sync_seen_ff;
    logic gap_short;
    logic hdr_pending_ff;

    assign gap_short = sync_seen_ff &&
        sync_gap_ff < 12'(dis_pkg::SECTOR_BYTES);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_gap_ff <= 12'h000;
            sync_seen_ff <= 1'b0;
        end else if (mode_ff != dec_mode) begin
            sync_gap_ff <= 12'h000;
            sync_seen_ff <= 1'b0;
        end else if (evt.sync_mark) begin
            sync_gap_ff <= 12'h000;
            sync_seen_ff <= 1'b1;
        end else if (evt.data_byte &&
                     sync_gap_ff < 12'(dis_pkg::SECTOR_BYTES)) begin
            sync_gap_ff <= sync_gap_ff + 12'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hdr_pending_ff <= 1'b0;
        end else if (evt.sync_mark) begin
            hdr_pending_ff <= search_mode && !(sync_window_open && gap_short);
        end else if (evt.header_byte || !search_mode) begin
            hdr_pending_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Audio byte count and timeout search
    // ------------------------------------------------------------
    logic [11:0] cdda_cnt_ff;
    logic cdda_sector;
    logic [31:0] tout_cnt_ff;
    logic tout_arm_ff;
    logic tout_hit;

    assign cdda_sector = dec_mode == dis_pkg::DIS_MODE_CDDA &&
        evt.buf_write && cdda_cnt_ff == 12'(dis_pkg::SECTOR_BYTES - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cdda_cnt_ff <= 12'h000;
        end else if (dec_mode != dis_pkg::DIS_MODE_CDDA) begin
            cdda_cnt_ff <= 12'h000;
        end else if (cdda_sector) begin
            cdda_cnt_ff <= 12'h000;
        end else if (evt.buf_write) begin
            cdda_cnt_ff <= cdda_cnt_ff + 12'h001;
        end
    end

    assign tout_hit = tout_arm_ff && !evt.sync_mark &&
        tout_cnt_ff == 32'(TIMEOUT_CYC - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tout_cnt_ff <= 32'h0000_0000;
            tout_arm_ff <= 1'b0;
        end else if (search_mode && mode_ff != dec_mode) begin
            tout_cnt_ff <= 32'h0000_0000;
            tout_arm_ff <= 1'b1;
        end else if (!search_mode || evt.sync_mark || tout_hit) begin
            tout_arm_ff <= 1'b0;
        end else if (tout_arm_ff) begin
            tout_cnt_ff <= tout_cnt_ff + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // Interval timer, counted in timer ticks
    // ------------------------------------------------------------
    logic [15:0] timer_cnt_ff;
    logic timer_run_ff;
    logic timer_start;
    logic timer_hit;

    assign timer_start = wr_acc && idx_ok &&
        idx == dis_pkg::IDX_TIMER_CTRL && wbyte[dis_pkg::BIT_TIMER_START];
    assign timer_hit = timer_run_ff && evt.timer_tick &&
        timer_cnt_ff == 16'h0001;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_cnt_ff <= 16'h0000;
            timer_run_ff <= 1'b0;
        end else if (timer_start) begin
            timer_cnt_ff <= {timer_hi_ff, timer_lo_ff};
            timer_run_ff <= {timer_hi_ff, timer_lo_ff} != 16'h0000;
        end else if (timer_hit) begin
            timer_cnt_ff <= 16'h0000;
            timer_run_ff <= 1'b0;
        end else if (timer_run_ff && evt.timer_tick) begin
            timer_cnt_ff <= timer_cnt_ff - 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Subcode sync staleness
    // ------------------------------------------------------------
    logic [6:0] stale_cnt_ff;
    logic subc_stale_ff;
    logic subc_take;
    logic [7:0] ts_sts_ff;

    assign subc_take = subc_fetch_en && evt.subc_sync && !subc_stale_ff;
    assign subcode_q_update = subc_take;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stale_cnt_ff <= 7'h00;
            subc_stale_ff <= 1'b0;
        end else if (!ts_sts_ff[dis_pkg::BIT_SUBC_SYNC] || subc_take) begin
            stale_cnt_ff <= 7'h00;
            subc_stale_ff <= 1'b0;
        end else if (evt.word_frame_clock_tick && !subc_stale_ff) begin
            stale_cnt_ff <= stale_cnt_ff + 7'h01;
            if (stale_cnt_ff == 7'(dis_pkg::SUBC_STALE_WORD_FRAME_CLOCK - 1)) begin
                subc_stale_ff <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    logic [7:0] evt_sts_ff;
    logic [7:0] evt_set;
    logic [7:0] ts_set;
    logic [7:0] evt_clr;
    logic [7:0] ts_clr;

    always_comb begin
        evt_set = 8'h00;
        evt_set[dis_pkg::BIT_DEC_EVENT] = (hdr_pending_ff && evt.header_byte)
            || (dec_mode == dis_pkg::DIS_MODE_REPEAT_CORR &&
                evt.corr_pass_done)
            || cdda_sector
            || (dec_mode == dis_pkg::DIS_MODE_SUBCODE_BUF &&
                evt.subc_sector_done);
        evt_set[dis_pkg::BIT_DEC_TIMEOUT] = tout_hit;
        evt_set[dis_pkg::BIT_DRV_OVERRUN] = overrun_mode && evt.buf_write &&
            buf_wr_addr == buf_limit_ff;
        evt_set[dis_pkg::BIT_CORR_DONE] = evt.corr_done;
        evt_set[dis_pkg::BIT_RECORDABLE] = evt.recordable_evt;
        evt_set[dis_pkg::BIT_SHORT_SYNC] = short_mode && evt.sync_mark &&
            gap_short;
        ts_set = 8'h00;
        ts_set[dis_pkg::BIT_TIMER] = timer_hit;
        ts_set[dis_pkg::BIT_SUBC_SYNC] = subc_take;
    end

    assign evt_clr = wr_evt_clr ? (wbyte & dis_pkg::EVT_MASK) : 8'h00;
    assign ts_clr = wr_ts_clr ? (wbyte & dis_pkg::TS_MASK) : 8'h00;

    // Set beats clear so no event is lost in the clearing cycle
    // Independent of enables
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_sts_ff <= dis_pkg::RST_BYTE;
            ts_sts_ff <= dis_pkg::RST_BYTE;
        end else begin
            evt_sts_ff <= (evt_sts_ff & ~evt_clr) | evt_set;
            ts_sts_ff <= (ts_sts_ff & ~ts_clr) | ts_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evt_sts_ff & evt_en_ff) || |(ts_sts_ff & ts_en_ff);
        end
    end

    // ------------------------------------------------------------
    // Read data, captured in the setup cycle
    // ------------------------------------------------------------
    logic [7:0] rbyte;
    logic [31:0] prdata_ff;
    logic pslverr_ff;

    always_comb begin
        unique case (idx)
            dis_pkg::IDX_EVT_STATUS: rbyte = evt_sts_ff;
            dis_pkg::IDX_TS_STATUS: rbyte = ts_sts_ff;
            dis_pkg::IDX_EVT_ENABLE: rbyte = evt_en_ff;
            dis_pkg::IDX_TS_ENABLE: rbyte = ts_en_ff;
            dis_pkg::IDX_TIMER_HIGH: rbyte = timer_hi_ff;
            dis_pkg::IDX_TIMER_LOW: rbyte = timer_lo_ff;
            dis_pkg::IDX_TIMER_CTRL: rbyte = {6'h00, timer_run_ff, 1'b0};
            default: rbyte = 8'h00;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (psel && !penable) begin
            pslverr_ff <= !idx_ok;
            if (!idx_ok || pwrite) begin
                prdata_ff <= 32'h0000_0000;
            end else if (idx == dis_pkg::IDX_BUF_LIMIT) begin
                prdata_ff <= {12'h000, buf_limit_ff};
            end else begin
                prdata_ff <= {24'h000000, rbyte};
            end
        end
    end

    assign prdata = prdata_ff;
    assign pslverr = pslverr_ff;

endmodule

// ### hw/dis_pkg.sv
package dis_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_EVT_STATUS = 8'h70;
    localparam logic [7:0] IDX_TS_STATUS = 8'h71;
    localparam logic [7:0] IDX_EVT_ENABLE = 8'h74;
    localparam logic [7:0] IDX_TS_ENABLE = 8'h75;
    localparam logic [7:0] IDX_TIMER_HIGH = 8'h78;
    localparam logic [7:0] IDX_TIMER_LOW = 8'h79;
    localparam logic [7:0] IDX_TIMER_CTRL = 8'h7a;
    localparam logic [7:0] IDX_BUF_LIMIT = 8'h7b;
    localparam int ADDR_W = 12;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_DEC_EVENT = 7;
    localparam int BIT_DEC_TIMEOUT = 6;
    localparam int BIT_DRV_OVERRUN = 5;
    localparam int BIT_CORR_DONE = 4;
    localparam int BIT_RECORDABLE = 3;
    localparam int BIT_SHORT_SYNC = 0;
    localparam int BIT_TIMER = 1;
    localparam int BIT_SUBC_SYNC = 0;
    localparam int BIT_TIMER_START = 0;
    localparam int BIT_TIMER_RUN = 1;
    localparam logic [7:0] EVT_MASK = 8'hf9;
    localparam logic [7:0] TS_MASK = 8'h03;

    // ------------------------------------------------------------
    // Reset values and sizes
    // ------------------------------------------------------------
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam int BUF_ADDR_W = 20;
    localparam logic [19:0] RST_BUF_LIMIT = 20'h00000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int SECTOR_BYTES = 2352;
    localparam int SUBC_STALE_WORD_FRAME_CLOCK = 95;
    localparam real CLK_PERIOD_NS = 10.0;
    localparam real DEC_TIMEOUT_MS = 40.6;
    localparam int DEC_TIMEOUT_CYC = int'($floor(DEC_TIMEOUT_MS * 1.0e6
        / CLK_PERIOD_NS));

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DIS_MODE_IDLE,
        DIS_MODE_MONITOR_ONLY,
        DIS_MODE_WRITE_ONLY,
        DIS_MODE_REALTIME_CORR,
        DIS_MODE_REPEAT_CORR,
        DIS_MODE_ASYNC_CORR,
        DIS_MODE_CDDA,
        DIS_MODE_SUBCODE_BUF
    } dis_mode_t;

    typedef struct packed {
        logic sync_mark;
        logic header_byte;
        logic data_byte;
        logic buf_write;
        logic corr_pass_done;
        logic corr_done;
        logic subc_sector_done;
        logic recordable_evt;
        logic subc_sync;
        logic word_frame_clock_tick;
        logic timer_tick;
    } dis_evt_t;

endpackage

// ### verification/dis_decoder_interrupt_status_assertions.sv
module dis_decoder_interrupt_status_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    // Decoder side
    input wire dis_pkg::dis_mode_t dec_mode,
    input wire dis_pkg::dis_evt_t evt,
    input wire logic subc_fetch_en,
    // Results
    input wire logic subcode_q_update,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Shadow state
    // ----------------------------------------
    logic wr;
    logic [2:0] wr_hist_ff;
    logic [7:0] en0_ff;
    logic [7:0] en1_ff;
    logic sflag_ff;
    logic [6:0] stale_ff;

    assign wr = psel && penable && pwrite && pready;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_hist_ff <= 3'h0;
            en0_ff <= 8'h00;
            en1_ff <= 8'h00;
        end else begin
            wr_hist_ff <= {wr_hist_ff[1:0], wr};
            if (wr && paddr == 12'h1d0) en0_ff <= pwdata[7:0];
            if (wr && paddr == 12'h1d4) en1_ff <= pwdata[7:0];
        end
    end

    // Ages only while the flag is set; a clear or a fresh set restarts it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sflag_ff <= 1'b0;
            stale_ff <= 7'h00;
        end else begin
            if (subcode_q_update) sflag_ff <= 1'b1;
            else if (wr && paddr == 12'h1c4 && pwdata[0]) sflag_ff <= 1'b0;
            if (!sflag_ff || subcode_q_update) stale_ff <= 7'h00;
            else if (evt.word_frame_clock_tick && stale_ff != 7'h7f)
                stale_ff <= stale_ff + 7'h01;
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_q_needs_sync: assert property (
        subcode_q_update |-> evt.subc_sync && subc_fetch_en)
        else $error("Subcode update without an accepted sync");
    chk_stale_block: assert property (
        sflag_ff && stale_ff >= 7'h5f && evt.subc_sync |-> !subcode_q_update)
        else $error("Stale subcode flag still accepted a sync");
    chk_reset_irq: assert property (
        disable iff (1'b0) !presetn |=> !irq)
        else $error("Interrupt active during reset");
    chk_irq_fall: assert property (
        $fell(irq) |-> |wr_hist_ff)
        else $error("Interrupt dropped without a register write");
    chk_corr_irq: assert property (
        en0_ff[4] && evt.corr_done |-> ##[1:3] irq)
        else $error("Correction done did not raise interrupt");
    chk_cdr_irq: assert property (
        en0_ff[3] && evt.recordable_evt |-> ##[1:3] irq)
        else $error("Recordable event did not raise interrupt");
    chk_repeat_irq: assert property (
        en0_ff[7] && dec_mode == dis_pkg::DIS_MODE_REPEAT_CORR &&
        evt.corr_pass_done |-> ##[1:3] irq)
        else $error("Correction pass did not raise interrupt");
    chk_subbuf_irq: assert property (
        en0_ff[7] && dec_mode == dis_pkg::DIS_MODE_SUBCODE_BUF &&
        evt.subc_sector_done |-> ##[1:3] irq)
        else $error("Subcode sector did not raise interrupt");
    chk_subc_irq: assert property (
        en1_ff[0] && subcode_q_update |-> ##[1:3] irq)
        else $error("Subcode sync did not raise interrupt");

    cov_stale: cover property (sflag_ff && stale_ff >= 7'h5f && evt.subc_sync);
    cov_irq: cover property ($rose(irq));
    cov_q: cover property (subcode_q_update);
endmodule

bind dis_decoder_interrupt_status dis_decoder_interrupt_status_chk u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .dec_mode(dec_mode), .evt(evt), .subc_fetch_en(subc_fetch_en),
    .subcode_q_update(subcode_q_update), .irq(irq)
);

// ### verification/dis_decoder_interrupt_status_bench.sv
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end

module dis_decoder_interrupt_status_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Signals and constants
    // ----------------------------------------
    localparam logic [11:0] S0 = 12'h1c0;
    localparam logic [11:0] S1 = 12'h1c4;
    localparam logic [11:0] E0 = 12'h1d0;
    localparam logic [11:0] E1 = 12'h1d4;
    localparam int SYNC = 10, HDR = 9, DATA = 8, BUFW = 7, PASS = 6;
    localparam int CDONE = 5, SSEC = 4, CDR = 3, SSYNC = 2, WORD_FRAME_CLOCK = 1;
    localparam int TICK = 0;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, sync_window_open = 1'b0, subc_fetch_en = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic [19:0] buf_wr_addr = 20'h0;
    logic pready, pslverr, subcode_q_update, irq, rerr, qseen;
    dis_pkg::dis_mode_t dec_mode = dis_pkg::DIS_MODE_IDLE;
    dis_pkg::dis_evt_t evt = '0;
    int n_checks = 0, n_mismatch = 0;

    // Short timeout keeps the search-timeout case brief
    dis_decoder_interrupt_status #(.TIMEOUT_CYC(50)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .dec_mode(dec_mode), .evt(evt),
        .sync_window_open(sync_window_open), .subc_fetch_en(subc_fetch_en),
        .buf_wr_addr(buf_wr_addr), .subcode_q_update(subcode_q_update),
        .irq(irq)
    );

    initial begin
        forever #5 pclk = ~pclk;
    end

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(rdata, x)
    endtask

    // One-cycle pulse on one event field, repeated n times
    task automatic ev(input int b, input int n = 1);
        repeat (n) begin
            @(posedge pclk);
            evt <= dis_pkg::dis_evt_t'(11'h001 << b);
            #1 qseen = subcode_q_update;
            @(posedge pclk);
            evt <= '0;
        end
    endtask

    task automatic md(input dis_pkg::dis_mode_t m);
        @(posedge pclk);
        dec_mode <= m;
    endtask

    task automatic test_done;
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        #400000;
        n_mismatch++;
        test_done;
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(S0, 32'h0);
        rd(S1, 32'h0);
        ev(CDONE);
        ev(CDR);
        rd(S0, 32'h18);
        `CHK(irq, 1'b0)
        wr(S0, 32'h10);
        rd(S0, 32'h08);
        wr(E0, 32'h18);
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b1)
        rd(E0, 32'h18);
        ev(CDONE);
        rd(S0, 32'h18);
        wr(S0, 32'h18);
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b0)
        md(dis_pkg::DIS_MODE_MONITOR_ONLY);
        ev(SYNC);
        ev(HDR);
        rd(S0, 32'h80);
        wr(S0, 32'hff);
        sync_window_open <= 1'b1;
        ev(SYNC);
        ev(HDR);
        rd(S0, 32'h01);
        wr(S0, 32'hff);
        ev(DATA, 2352);
        ev(SYNC);
        ev(HDR);
        rd(S0, 32'h80);
        wr(S0, 32'hff);
        sync_window_open <= 1'b0;
        for (int m = 0; m < 8; m++) begin
            md(dis_pkg::dis_mode_t'(m));
            ev(SYNC, 2);
            rd(S0, (m inside {1, 2, 3, 5}) ? 32'h01 : 32'h00);
            wr(S0, 32'hff);
        end
        md(dis_pkg::DIS_MODE_IDLE);
        md(dis_pkg::DIS_MODE_WRITE_ONLY);
        repeat (20) @(posedge pclk);
        rd(S0, 32'h0);
        repeat (40) @(posedge pclk);
        rd(S0, 32'h40);
        wr(S0, 32'hff);
        wr(E0, 32'hff);
        wr(12'h1ec, 32'h64);
        rd(12'h1ec, 32'h64);
        md(dis_pkg::DIS_MODE_CDDA);
        for (int i = 0; i < 2352; i++) begin
            if (i == 2351) rd(S0, 32'h20);
            buf_wr_addr <= 20'(i);
            ev(BUFW);
        end
        rd(S0, 32'ha0);
        wr(S0, 32'hff);
        md(dis_pkg::DIS_MODE_REPEAT_CORR);
        ev(PASS);
        rd(S0, 32'h80);
        wr(S0, 32'hff);
        md(dis_pkg::DIS_MODE_SUBCODE_BUF);
        ev(SSEC);
        rd(S0, 32'h80);
        wr(S0, 32'hff);
        md(dis_pkg::DIS_MODE_IDLE);
        wr(12'h1e0, 32'h0);
        wr(12'h1e4, 32'h3);
        wr(12'h1e8, 32'h1);
        rd(12'h1e8, 32'h2);
        ev(TICK, 2);
        rd(S1, 32'h0);
        ev(TICK);
        rd(S1, 32'h02);
        `CHK(irq, 1'b0)
        wr(S1, 32'h02);
        rd(S1, 32'h0);
        ev(SSYNC);
        `CHK(qseen, 1'b0)
        subc_fetch_en <= 1'b1;
        ev(SSYNC);
        `CHK(qseen, 1'b1)
        rd(S1, 32'h01);
        ev(WORD_FRAME_CLOCK, 100);
        ev(SSYNC);
        `CHK(qseen, 1'b0)
        wr(S1, 32'h01);
        rd(S1, 32'h0);
        wr(E1, 32'h01);
        rd(E1, 32'h01);
        ev(SSYNC);
        `CHK(qseen, 1'b1)
        repeat (3) @(posedge pclk);
        `CHK(irq, 1'b1)
        apb(1'b0, 12'h1f0, 32'h0);
        `CHK(rerr, 1'b1)
        `CHK(rdata, 32'h0)
        ev(CDR);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        presetn <= 1'b1;
        rd(S0, 32'h0);
        rd(S1, 32'h0);
        rd(E0, 32'h0);
        test_done;
    end
endmodule
